// ===== verilog/led_link_consts.svh
`ifndef LED_LINK_CONSTS_SVH
`define LED_LINK_CONSTS_SVH

// Reserved reset-call address byte, write direction
`define RST_CALL_ADDR_W     8'h06
`define RST_CALL_ADDR_R     8'h07
`define RST_KEY1            8'ha5
`define RST_KEY2            8'h5a
`define LED_CHANNELS        16
// Clock and bus timing
`define CLK_PERIOD_NS       10
`define LINK_HALF_NS        500
`define LINK_HALF_CYC       (((`LINK_HALF_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
// Individual PWM at 97 kHz, 256 steps: 100 MHz / (97 kHz * 256) rounded down
`define IND_PWM_HZ          97000
`define IND_TICK_CYC        (100000000 / (`IND_PWM_HZ * 256))
// Group dimming at 190 Hz, 256 steps
`define GRP_DIM_HZ          190
`define GRP_TICK_CYC        (100000000 / (`GRP_DIM_HZ * 256))
// Group blink base rate 24 Hz, 256 steps per period, period = (freq + 1) / 24 s
`define BLINK_HZ            24
`define BLINK_TICK_CYC      (100000000 / (`BLINK_HZ * 256))
// Register defaults after power-on or reset call
`define DUTY_RESET          8'h00
`define GRP_DUTY_RESET      8'hff
`define GRP_FREQ_RESET      8'h00

`endif

// ===== verilog/led_link_pkg.sv
package led_link_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_KEY1,
        ST_KEY2,
        ST_ARMED,
        ST_DEAD
    } call_state_e;

    typedef enum logic [2:0] {
        M_IDLE,
        M_START,
        M_BITS,
        M_STOP,
        M_DONE
    } mast_state_e;
endpackage

// ===== verilog/led_bus_if.sv
interface led_bus_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_d_o;
    logic sda_d_oe;
    logic [15:0] led_o;
    logic [15:0] led_oe;
    logic out_enable_n;
    // Open-drain wires resolved from the enables, pulled high when released
    wire scl = ~(scl_oe & ~scl_o);
    wire sda = ~(sda_m_oe & ~sda_m_o) & ~(sda_d_oe & ~sda_d_o);

    modport device (
        input  scl,
        input  sda,
        input  out_enable_n,
        output sda_d_o,
        output sda_d_oe,
        output led_o,
        output led_oe
    );
    modport master (
        input  sda,
        output scl_o,
        output scl_oe,
        output sda_m_o,
        output sda_m_oe,
        output out_enable_n
    );
endinterface

// ===== verilog/led_bus_device.sv
`include "led_link_consts.svh"
// Summary of operation
// - Output enable low lets LEDs follow state
// - Output enable high floats every LED output
// - Master avoids pin blinking during group blinking
// - Master avoids pin dimming during group dimming
// - Reset clears registers and bus machine
// - Acknowledge only the reserved write address
// - Reserved address with read gets no acknowledge
// - First key byte acknowledged only if matching
// - Second key byte acknowledged only if matching
// - No acknowledge beyond second data byte
// - STOP after both keys resets all registers
// - Master treats any no-acknowledge as abort
// - Malformed call never resets the registers
// - Per-channel 8-bit PWM at fixed rate
// - Group dimming overlays slower 8-bit duty signal
// - Group blinking overlays programmable period and duty
// - SDA change during SCL high is control
// - SDA fall is START, rise is STOP
// - Acknowledge on the ninth clock when receiving
// - Transmitter releases SDA after final master NACK
// - Acknowledger holds SDA low through clock high
// - Master starts only when bus idle
// - Blink select picks blinking or dimming
module led_bus_device
    import led_link_pkg::*;
(
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    led_bus_if.device                bus,
    input  wire logic [127:0]        led_duty,
    input  wire logic [31:0]         led_mode,
    input  wire logic [7:0]          grp_duty,
    input  wire logic [7:0]          grp_freq,
    input  wire logic                group_blink_select,
    output logic                     bus_reset_call,
    output logic [2:0]               call_state
);
    ////////////////////////////////////////////////////////////////////////
    // Two-stage sampling of the link pins and edge finding
    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic       scl_q;
    logic       sda_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_q      <= 1'b1;
            sda_q      <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], bus.scl};
            sda_sync_q <= {sda_sync_q[0], bus.sda};
            scl_q      <= scl_sync_q[1];
            sda_q      <= sda_sync_q[1];
        end
    end
    wire scl_s   = scl_sync_q[1];
    wire sda_s   = sda_sync_q[1];
    wire scl_ris = scl_s & ~scl_q;
    wire scl_fal = ~scl_s & scl_q;
    // Data moving while the clock is high is a control condition
    wire start_c = scl_s & scl_q & sda_q & ~sda_s;
    wire stop_c  = scl_s & scl_q & ~sda_q & sda_s;

    ////////////////////////////////////////////////////////////////////////
    // Byte receiver: eight data bits then the acknowledge slot
    logic [7:0]  shift_q;
    logic [3:0]  bit_cnt_q;
    logic        ack_q;
    logic        active_q;
    call_state_e state_q;
    call_state_e state_d;
    wire         byte_done = scl_ris & active_q & (bit_cnt_q == 4'h7);
    wire [7:0]   byte_val  = {shift_q[6:0], sda_s};
    wire         ack_slot_end = scl_fal & (bit_cnt_q == 4'h9);

    // Acknowledge decision per call stage
    wire want_ack = (state_q == ST_ADDR && byte_val == `RST_CALL_ADDR_W)
                  | (state_q == ST_KEY1 && byte_val == `RST_KEY1)
                  | (state_q == ST_KEY2 && byte_val == `RST_KEY2);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:  state_d = ST_IDLE;
            ST_ADDR:  state_d = want_ack ? ST_KEY1 : ST_DEAD;
            ST_KEY1:  state_d = want_ack ? ST_KEY2 : ST_DEAD;
            ST_KEY2:  state_d = want_ack ? ST_ARMED : ST_DEAD;
            ST_ARMED: state_d = ST_DEAD;
            ST_DEAD:  state_d = ST_DEAD;
            default:  state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= ST_IDLE;
            shift_q   <= 8'h00;
            bit_cnt_q <= 4'h0;
            ack_q     <= 1'b0;
            active_q  <= 1'b0;
        end else if (start_c) begin
            state_q   <= ST_ADDR;
            bit_cnt_q <= 4'h0;
            ack_q     <= 1'b0;
            active_q  <= 1'b1;
        end else if (stop_c) begin
            state_q  <= ST_IDLE;
            ack_q    <= 1'b0;
            active_q <= 1'b0;
        end else if (active_q) begin
            if (scl_ris && bit_cnt_q < 4'h8) begin
                shift_q <= byte_val;
            end
            if (byte_done) begin
                state_q <= state_d;
                ack_q   <= want_ack;
            end
            if (scl_ris) begin
                bit_cnt_q <= (bit_cnt_q == 4'h8) ? 4'h9 : bit_cnt_q + 4'h1;
            end else if (ack_slot_end) begin
                bit_cnt_q <= 4'h0;
                ack_q     <= 1'b0;
            end else if (scl_fal && bit_cnt_q == 4'h8) begin
                bit_cnt_q <= 4'h8;
            end
        end
    end

    // Low from the fall after bit eight to the fall after the ninth clock
    wire ack_drive = ack_q & (bit_cnt_q == 4'h8 ? ~scl_s | 1'b1 : bit_cnt_q == 4'h9);
    assign bus.sda_d_o  = 1'b0;
    assign bus.sda_d_oe = ack_drive & ~(bit_cnt_q == 4'h8 & scl_q & scl_s);

    // Reset pulse only on STOP after both keys were taken
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bus_reset_call <= 1'b0;
        end else begin
            bus_reset_call <= stop_c & (state_q == ST_ARMED);
        end
    end
    assign call_state = state_q;

    ////////////////////////////////////////////////////////////////////////
    // Rate dividers: one-cycle enables
    logic [9:0]  ind_div_q;
    logic [11:0] grp_div_q;
    logic [15:0] blk_div_q;
    logic [7:0]  ind_cnt_q;
    logic [7:0]  grp_cnt_q;
    logic [7:0]  blk_step_q;
    logic [7:0]  blk_rep_q;
    wire ind_tick = (ind_div_q == 10'((`IND_TICK_CYC) - 1));
    wire grp_tick = (grp_div_q == 12'((`GRP_TICK_CYC) - 1));
    wire blk_tick = (blk_div_q == 16'((`BLINK_TICK_CYC) - 1));
    // Blink steps advance every (freq + 1) base ticks, giving (freq + 1) / 24 s
    wire blk_adv  = blk_tick & (blk_rep_q == grp_freq);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ind_div_q  <= 10'h000;
            grp_div_q  <= 12'h000;
            blk_div_q  <= 16'h0000;
            ind_cnt_q  <= 8'h00;
            grp_cnt_q  <= 8'h00;
            blk_step_q <= 8'h00;
            blk_rep_q  <= 8'h00;
        end else begin
            ind_div_q <= ind_tick ? 10'h000 : ind_div_q + 10'h001;
            grp_div_q <= grp_tick ? 12'h000 : grp_div_q + 12'h001;
            blk_div_q <= blk_tick ? 16'h0000 : blk_div_q + 16'h0001;
            if (ind_tick) ind_cnt_q <= ind_cnt_q + 8'h01;
            if (grp_tick) grp_cnt_q <= grp_cnt_q + 8'h01;
            if (blk_tick) blk_rep_q <= blk_adv ? 8'h00 : blk_rep_q + 8'h01;
            if (blk_adv) blk_step_q <= blk_step_q + 8'h01;
        end
    end

    // Group gate: blinking or dimming by the select bit
    wire grp_on = group_blink_select ? (blk_step_q < grp_duty)
                                     : (grp_cnt_q < grp_duty);

    ////////////////////////////////////////////////////////////////////////
    // Per-channel output: 00 off, 01 on, 10 individual, 11 individual and group
    logic [15:0] led_q;
    genvar ch;
    generate
        for (ch = 0; ch < `LED_CHANNELS; ch = ch + 1) begin : g_ch
            wire [1:0] mode = led_mode[2*ch +: 2];
            wire       pwm  = ind_cnt_q < led_duty[8*ch +: 8];
            wire       lit  = (mode == 2'h1) | (mode == 2'h2 & pwm) | (mode == 2'h3 & pwm & grp_on);
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    led_q[ch] <= 1'b1;
                end else begin
                    led_q[ch] <= ~lit;  // Low sinks current, LED on
                end
            end
        end
    endgenerate

    // Enable pin is asynchronous to outputs by design: applied without sampling
    assign bus.led_o  = led_q;
    assign bus.led_oe = {16{~bus.out_enable_n}};
endmodule

// ===== verilog/led_bus_master.sv
`include "led_link_consts.svh"
// Issues START, a byte string with acknowledge sampling, then STOP.
module led_bus_master
    import led_link_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    led_bus_if.master        bus,
    input  wire logic        go,
    input  wire logic [1:0]  last_idx,
    input  wire logic [31:0] tx_bytes,
    input  wire logic        oe_n_req,
    output logic             busy,
    output logic             aborted,
    output logic [3:0]       ack_seen
);
    mast_state_e st_q;
    logic [8:0]  div_q;
    logic [1:0]  phase_q;
    logic [3:0]  bit_q;
    logic [1:0]  idx_q;
    logic        scl_q;
    logic        sda_q;
    logic [1:0]  sda_sync_q;
    logic        oe_n_q;
    wire tick = (div_q == 9'((`LINK_HALF_CYC) - 1));
    wire [7:0] cur = tx_bytes[8*idx_q +: 8];
    wire bus_idle = sda_sync_q[1];
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= M_IDLE;
            div_q <= 9'h000;
            phase_q <= 2'h0;
            bit_q <= 4'h0;
            idx_q <= 2'h0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            sda_sync_q <= 2'h3;
            oe_n_q <= 1'b1;
            aborted <= 1'b0;
            ack_seen <= 4'h0;
        end else begin
            sda_sync_q <= {sda_sync_q[0], bus.sda};
            oe_n_q <= oe_n_req;
            div_q <= tick ? 9'h000 : div_q + 9'h001;
            case (st_q)
                M_IDLE: if (go && bus_idle) begin
                    st_q <= M_START;
                    aborted <= 1'b0;
                    ack_seen <= 4'h0;
                    idx_q <= 2'h0;
                end
                M_START: if (tick) begin
                    sda_q <= 1'b0;
                    st_q <= M_BITS;
                    bit_q <= 4'h0;
                    phase_q <= 2'h0;
                end
                M_BITS: if (tick) begin
                    phase_q <= phase_q + 2'h1;
                    case (phase_q)
                        2'h0: scl_q <= 1'b0;
                        2'h1: sda_q <= (bit_q == 4'h8) ? 1'b1 : cur[3'(7 - bit_q)];
                        2'h2: scl_q <= 1'b1;
                        default: begin
                            if (bit_q == 4'h8) begin
                                ack_seen[idx_q] <= ~sda_sync_q[1];
                                bit_q <= 4'h0;
                                if (sda_sync_q[1] || idx_q == last_idx) begin
                                    aborted <= sda_sync_q[1];
                                    st_q <= M_STOP;
                                    phase_q <= 2'h0;
                                end else begin
                                    idx_q <= idx_q + 2'h1;
                                end
                            end else begin
                                bit_q <= bit_q + 4'h1;
                            end
                        end
                    endcase
                end
                M_STOP: if (tick) begin
                    phase_q <= phase_q + 2'h1;
                    case (phase_q)
                        2'h0: scl_q <= 1'b0;
                        2'h1: sda_q <= 1'b0;
                        2'h2: scl_q <= 1'b1;
                        default: begin
                            sda_q <= 1'b1;
                            st_q <= M_DONE;
                        end
                    endcase
                end
                M_DONE: if (tick) st_q <= M_IDLE;
                default: st_q <= M_IDLE;
            endcase
        end
    end
    assign busy = (st_q != M_IDLE);
    assign bus.scl_o = 1'b0;
    assign bus.scl_oe = ~scl_q;
    assign bus.sda_m_o = 1'b0;
    assign bus.sda_m_oe = ~sda_q;
    assign bus.out_enable_n = oe_n_q;  // Kept static by the user during group modes
endmodule

// ===== sim/led_bus_asserts.sv
module led_bus_asserts (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        scl,
    input wire logic        sda,
    input wire logic        sda_d_o,
    input wire logic        sda_d_oe,
    input wire logic [15:0] led_o,
    input wire logic [15:0] led_oe,
    input wire logic        out_enable_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       scl_q;
    logic       sda_q;
    logic [3:0] bit_q;
    logic [2:0] byte_q;
    logic [7:0] sh_q;
    wire        rise_w    = scl & ~scl_q;
    wire        start_w   = scl & scl_q & sda_q & ~sda;
    wire        dev_low_w = sda_d_oe & ~sda_d_o;
    ////////////////////////////////////////////////////////////////////////////////
    // Bit and byte position since START, plus the byte seen on the wire
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            scl_q  <= 1'b1;
            sda_q  <= 1'b1;
            bit_q  <= 4'h0;
            byte_q <= 3'h0;
            sh_q   <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (start_w) begin
                bit_q  <= 4'h0;
                byte_q <= 3'h0;
            end else if (rise_w) begin
                bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
                sh_q  <= {sh_q[6:0], sda};
                if (bit_q == 4'h8) begin
                    byte_q <= byte_q + 3'h1;
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_ack_rise;
        rise_w && dev_low_w;
    endsequence
    property p_oe_on;     !out_enable_n |-> led_oe == 16'hffff; endproperty
    property p_oe_off;    out_enable_n |-> led_oe == 16'h0000; endproperty
    property p_por;       $rose(rst_n) |-> led_o == 16'hffff && !sda_d_oe; endproperty
    property p_sda_still; (scl && scl_q) |-> $stable(dev_low_w); endproperty
    property p_ack_hold;  s_ack_rise |-> !sda [*8]; endproperty
    property p_ack_slot;  s_ack_rise |-> bit_q == 4'h8; endproperty
    property p_no_third;  s_ack_rise |-> byte_q < 3'h3; endproperty
    property p_addr;      (s_ack_rise ##0 byte_q == 3'h0) |-> sh_q == 8'h06; endproperty
    property p_key1;      (s_ack_rise ##0 byte_q == 3'h1) |-> sh_q == 8'ha5; endproperty
    property p_key2;      (s_ack_rise ##0 byte_q == 3'h2) |-> sh_q == 8'h5a; endproperty
    property p_start_rel; start_w |-> !sda_d_oe [*8]; endproperty
    a_oe_on: assert property (p_oe_on) else $error("outputs not enabled");
    a_oe_off: assert property (p_oe_off) else $error("outputs not floated");
    a_por: assert property (p_por) else $error("bad state after reset");
    a_sda_still: assert property (p_sda_still) else $error("data moved in clock high");
    a_ack_hold: assert property (p_ack_hold) else $error("ack not held low");
    a_ack_slot: assert property (p_ack_slot) else $error("ack off the ninth clock");
    a_no_third: assert property (p_no_third) else $error("third data byte acked");
    a_addr: assert property (p_addr) else $error("wrong address acked");
    a_key1: assert property (p_key1) else $error("wrong first key acked");
    a_key2: assert property (p_key2) else $error("wrong second key acked");
    a_start_rel: assert property (p_start_rel) else $error("data held after start");
endmodule

// ===== sim/led_driver_bus_reset_enable_bench.sv
`include "led_link_consts.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module led_driver_bus_reset_enable_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import led_link_pkg::*;
    logic         clk_sys;
    logic         rst_n;
    logic         go;
    logic [1:0]   last_idx;
    logic [31:0]  tx_bytes;
    logic         oe_n_req;
    logic         busy;
    logic         aborted;
    logic [3:0]   ack_seen;
    logic [127:0] led_duty;
    logic [31:0]  led_mode;
    logic [7:0]   grp_duty;
    logic [7:0]   grp_freq;
    logic         group_blink_select;
    logic         bus_reset_call;
    logic [2:0]   call_state;
    logic [15:0]  exp_led;
    logic [7:0]   k;
    int           bad_count;
    int           checks;
    int           pulses;
    led_bus_if bus ();
    led_bus_device led_bus_device_i (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus),
        .led_duty(led_duty), .led_mode(led_mode), .grp_duty(grp_duty), .grp_freq(grp_freq),
        .group_blink_select(group_blink_select), .bus_reset_call(bus_reset_call),
        .call_state(call_state));
    led_bus_master led_bus_master_i (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .go(go),
        .last_idx(last_idx), .tx_bytes(tx_bytes), .oe_n_req(oe_n_req), .busy(busy),
        .aborted(aborted), .ack_seen(ack_seen));
    led_bus_asserts led_bus_asserts_i (.clk_sys(clk_sys), .rst_n(rst_n), .scl(bus.scl),
        .sda(bus.sda), .sda_d_o(bus.sda_d_o), .sda_d_oe(bus.sda_d_oe), .led_o(bus.led_o),
        .led_oe(bus.led_oe), .out_enable_n(bus.out_enable_n));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (bus_reset_call === 1'b1) pulses++;
    end
    task automatic summarize();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wait_for(input logic lvl);
        int n;
        n = 0;
        while (busy !== lvl && n < 40000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 40000) begin
            bad_count++;
            summarize();
        end
    endtask
    // Reference model: each byte must match its slot in the call, a miss ends it
    task automatic run_call(input string name, input logic [31:0] b, input logic [1:0] li);
        logic [3:0] ea;
        logic       ok;
        int         key [4] = '{'h06, 'ha5, 'h5a, 256};
        ea = 4'h0;
        ok = 1'b1;
        for (int i = 0; i <= li; i++) begin
            ok = ok && (b[8*i +: 8] == key[i]);
            ea[i] = ok;
        end
        pulses = 0;
        @(posedge clk_sys);
        #1;
        tx_bytes = b;
        last_idx = li;
        go = 1'b1;
        wait_for(1'b1);
        go = 1'b0;
        wait_for(1'b0);
        repeat (20) @(posedge clk_sys);
        #1;
        `CHK(ack_seen, ea)
        `CHK(aborted, ~ok)
        `CHK(pulses, (ok && li == 2'd2) ? 1 : 0)
        `CHK(call_state, 3'h0)
        $display("test %s done", name);
        // Idle gap stands in for the bus free time
        repeat (300) @(posedge clk_sys);
    endtask
    // Lit cycles over one individual period: duty / 256 of it, none with group duty zero
    task automatic run_pwm(input string name, input logic [1:0] md);
        int lit [16];
        int exp_lit;
        @(posedge clk_sys);
        #1;
        for (int i = 0; i < 16; i++) begin
            lit[i] = 0;
            led_duty[8*i +: 8] = 8'($urandom_range(255));
            led_mode[2*i +: 2] = md;
        end
        repeat (4) @(posedge clk_sys);
        repeat (256 * `IND_TICK_CYC) begin
            @(posedge clk_sys);
            #1;
            for (int i = 0; i < 16; i++) begin
                lit[i] += (bus.led_o[i] === 1'b0) ? 1 : 0;
            end
        end
        for (int i = 0; i < 16; i++) begin
            exp_lit = (md == 2'h2) ? led_duty[8*i +: 8] * `IND_TICK_CYC : 0;
            `CHK(lit[i], exp_lit)
        end
        $display("test %s done", name);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        go = 1'b0;
        last_idx = 2'd0;
        tx_bytes = 32'h0;
        oe_n_req = 1'b1;
        led_duty = 128'h0;
        led_mode = 32'h0;
        grp_duty = 8'h00;
        grp_freq = 8'h00;
        group_blink_select = 1'b0;
        bad_count = 0;
        checks = 0;
        pulses = 0;
        void'($urandom(32'h2894));
        repeat (5) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        `CHK(bus.led_o, 16'hffff)
        `CHK(bus_reset_call, 1'b0)
        for (int i = 0; i < 16; i++) begin
            led_duty[8*i +: 8] = 8'($urandom_range(255));
            led_mode[2*i +: 2] = {1'b0, 1'($urandom_range(1))};
            exp_led[i] = ~led_mode[2*i];
        end
        grp_duty = 8'($urandom_range(255));
        grp_freq = 8'($urandom_range(255));
        group_blink_select = 1'($urandom_range(1));
        // Held steady while any group overlay runs
        oe_n_req = 1'b0;
        repeat (20) @(posedge clk_sys);
        #1;
        `CHK(bus.led_oe, 16'hffff)
        `CHK(bus.led_o, exp_led)
        $display("test leds done");
        run_call("good", 32'h005aa506, 2'd2);
        run_call("read", 32'h00000007, 2'd0);
        k = 8'($urandom_range(255));
        if (k == 8'ha5) k = 8'h00;
        run_call("key1", {16'h0000, k, 8'h06}, 2'd1);
        k = 8'($urandom_range(255));
        if (k == 8'h5a) k = 8'h00;
        run_call("key2", {8'h00, k, 8'ha5, 8'h06}, 2'd2);
        run_call("extra", {8'($urandom_range(255)), 24'h5aa506}, 2'd3);
        run_call("again", 32'h005aa506, 2'd2);
        run_pwm("pwm", 2'h2);
        grp_duty = 8'h00;
        run_pwm("group", 2'h3);
        oe_n_req = 1'b1;
        repeat (20) @(posedge clk_sys);
        #1;
        `CHK(bus.led_oe, 16'h0000)
        $display("test float done");
        summarize();
    end
    initial begin
        // Whole run needs about 36,000 cycles; this allows roughly twice that
        #800000;
        bad_count++;
        summarize();
    end
endmodule
